// file: hw/sbe_pkg.sv
/*
  shared types and constants for the system bus error handler.
  assumes one 200 MHz clock and a synchronous active-low reset.
*/
package sbe_pkg;
  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 32;      // real address width
  localparam int NBYTES        = 4;       // bytes per data beat
  localparam int CLK_PERIOD_NS = 5;       // 200 MHz
  localparam int BUS_TMO_NS    = 100000;  // bus transaction guard time
  localparam int DISP_TMO_NS   = 200000;  // dispatch guard time
  localparam int BUS_TMO_CYC   = BUS_TMO_NS / CLK_PERIOD_NS;
  localparam int DISP_TMO_CYC  = DISP_TMO_NS / CLK_PERIOD_NS;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;  // timer value after reset

  // logged error kinds, lowest priority first
  typedef enum logic [2:0] {
    ERR_NONE, ERR_TIMEOUT, ERR_INTERNAL, ERR_RANGE, ERR_DATA_PAR, ERR_ADDR_PAR
  } err_code_t;

  // one bus request as seen on the shared bus
  typedef struct packed {
    logic                  valid;       // request present this cycle
    logic [ADDR_W-1:0]     addr;        // real address
    logic [NBYTES-1:0]     addr_par;    // odd parity, one bit per address byte
    logic [8*NBYTES-1:0]   data;        // write data
    logic [NBYTES-1:0]     data_par;    // odd parity per write data byte
    logic                  is_write;    // store
    logic                  expect_rsp;  // a response will follow
    logic                  direct_store;// direct_store_segment access
    logic                  dma;         // dma request
  } txn_t;

  // response to the outstanding request
  typedef struct packed {
    logic                  valid;
    logic [8*NBYTES-1:0]   data;
    logic [NBYTES-1:0]     data_par;
  } rsp_t;

  // exception register contents
  typedef struct packed {
    logic                  valid;       // holds an event
    err_code_t             code;        // kind of event
    logic [ADDR_W-1:0]     addr;        // address of the failing access
    logic [NBYTES-1:0]     addr_par;    // received address parity bits
    logic [NBYTES-1:0]     bad_bytes;   // failing data bytes
  } exc_log_t;

  // outward signalling
  typedef struct packed {
    logic ext_int;        // external interrupt pulse
    logic machine_check;  // machine check pulse
    logic dsi;            // data storage interrupt pulse
    logic bus_check;      // data transfer error pulse
    logic abort_op;       // operation aborted pulse
    logic checkstop_out;  // own checkstop, held until reset
    logic sys_reset_out;  // system reset request, registered copy of reset_req
  } sig_t;
endpackage

// file: hw/sys_bus_error_handler.sv
/*
  error detection, logging and signalling for one bus unit controller.
  assumes request and response structs come from logic on clk; the
  system checkstop line arrives from other parties and is synchronised.
*/
`timescale 1ns/1ps

// Contract
// RQ1: out-of-region-extent address logs range error, interrupts
// RQ2: diagnostic mode reports range error externally
// RQ3: unchecked out-of-range read ends in time-out
// RQ4: address parity error above class two checkstops
// RQ5: each controller checks address parity itself
// RQ6: capture address parity bits and address
// RQ7: log address parity error; diagnostic adds checkstop
// RQ8: deferred write parity error aborts, no interrupt
// RQ9: store failing bytes; diagnostic raises external interrupt
// RQ10: memory-mapped data parity error gives machine check
// RQ11: direct_store_segment data parity error gives storage interrupt
// RQ12: dma read parity error aborts, external interrupt
// RQ13: internal errors: storage or external interrupt
// RQ14: drive checkstop out on own entry
// RQ15: enter checkstop when system checkstop asserted
// RQ16: guard responses and dispatch with timers
// RQ17: log time-out with address, central timer
// RQ18: provide interrupt, checkstop, reset, bus check
// RQ19: parity pins, internal errors, dispatch time-out
// RQ20: controller checkstop, reset, interrupt, parity pins
// RQ21: master time-out detection above class three
// RQ22: diagnostic mode bit steers error reporting
// RQ23: read-only log, cleared on read, first event
// RQ24: captured log held until software reads
module sys_bus_error_handler
  import sbe_pkg::*;
#(
  parameter int          SYS_CLASS      = 6,            // implementation category
  parameter bit          RANGE_CHECK    = 1'b1,         // dedicated range checker
  parameter bit          DEFER_WR_ERR   = 1'b1,         // defer write parity errors
  parameter logic [31:0] BUS_TMO_LIMIT  = BUS_TMO_CYC,  // bus time-out in cycles
  parameter logic [31:0] DISP_TMO_LIMIT = DISP_TMO_CYC  // dispatch time-out in cycles
) (
  // clock and reset
  input  wire  logic              clk,
  input  wire  logic              rstn,
  // bus traffic
  input  wire  txn_t              txn,
  input  wire  rsp_t              rsp,
  // configuration
  input  wire  logic              diag_mode,
  input  wire  logic [ADDR_W-1:0] region_lo,
  input  wire  logic [ADDR_W-1:0] region_hi,
  input  wire  logic [ADDR_W-1:0] installed_top,
  // internal events
  input  wire  logic              int_err,
  input  wire  logic              int_fatal,
  input  wire  logic              disp_pending,
  input  wire  logic              disp_done,
  input  wire  logic              reset_req,
  // system checkstop pin
  input  wire  logic              checkstop_in,
  // exception register read
  input  wire  logic              log_read,
  output logic                    log_valid,
  output err_code_t               log_code,
  output logic [ADDR_W-1:0]       log_addr,
  output logic [NBYTES-1:0]       log_addr_par,
  output logic [NBYTES-1:0]       log_bad_bytes,
  // signalling
  output sig_t                    sig,
  output logic                    in_checkstop
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              cs_meta;   // checkstop pin, first stage
    logic              cs_sync;   // checkstop pin, second stage
    logic              stopped;   // checkstop state
    exc_log_t          log;       // exception register
    sig_t              sig;       // outward signals
    logic              busy;      // one transaction outstanding
    logic              busy_ds;   // it is a direct_store_segment access
    logic              busy_dma;  // it is a dma read
    logic [ADDR_W-1:0] busy_addr; // its address
    logic [31:0]       tmr;       // bus timer
    logic [31:0]       wd;        // dispatch timer
  } st_t;

  st_t st;       // registered state
  st_t next_st;  // next state

  localparam bit ABOVE_C2 = (SYS_CLASS > 2);
  localparam bit ABOVE_C3 = (SYS_CLASS > 3);

  // ----------------------------------------------------------------
  // parity checks
  // ----------------------------------------------------------------
  logic [NBYTES-1:0] abad;  // failing address bytes
  logic [NBYTES-1:0] wbad;  // failing write data bytes
  logic [NBYTES-1:0] rbad;  // failing read data bytes

  // RQ5: own parity check
  genvar g;
  generate
    for (g = 0; g < NBYTES; g++) begin : g_par
      assign abad[g] = txn.addr_par[g] == ^txn.addr[8*g +: 8];
      assign wbad[g] = txn.data_par[g] == ^txn.data[8*g +: 8];
      assign rbad[g] = rsp.data_par[g] == ^rsp.data[8*g +: 8];
    end
  endgenerate

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  logic ap_err;    // address parity error
  logic rng_err;   // address range error
  logic wdp_err;   // write data parity error
  logic rdp_err;   // read data parity error
  logic rdp_ds;    // on a direct_store_segment access
  logic rdp_dma;   // on a dma read
  logic rdp_mem;   // on a memory-mapped access
  logic bus_tmo;   // bus time-out
  logic disp_tmo;  // dispatch time-out
  logic own_stop;  // own cause for checkstop

  always_comb begin
    ap_err   = txn.valid & (|abad);
    // RQ3: without checker reads time out
    // RQ1: region and extent check
    rng_err  = RANGE_CHECK & txn.valid & (txn.addr >= region_lo) &
               (txn.addr <= region_hi) & (txn.addr >= installed_top);
    wdp_err  = txn.valid & txn.is_write & (|wbad);
    rdp_err  = rsp.valid & st.busy & (|rbad);
    rdp_ds   = rdp_err & st.busy_ds;
    rdp_dma  = rdp_err & st.busy_dma & ~st.busy_ds;
    rdp_mem  = rdp_err & ~st.busy_ds & ~st.busy_dma;
    // RQ21: master time-out
    bus_tmo  = ABOVE_C3 & st.busy & ~rsp.valid & (st.tmr >= BUS_TMO_LIMIT - 32'h1);
    // RQ19: dispatch time-out
    disp_tmo = ABOVE_C3 & disp_pending & ~disp_done & (st.wd >= DISP_TMO_LIMIT - 32'h1);
    // RQ7: diagnostic mode checkstops too
    // RQ4: address parity checkstop
    own_stop = int_fatal | disp_tmo | (ap_err & (ABOVE_C2 | diag_mode));
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.cs_meta    = checkstop_in;
    next_st.cs_sync    = st.cs_meta;
    // pulses last one cycle
    next_st.sig.ext_int       = 1'b0;
    next_st.sig.machine_check = 1'b0;
    next_st.sig.dsi           = 1'b0;
    next_st.sig.bus_check     = 1'b0;
    next_st.sig.abort_op      = 1'b0;
    // RQ18: reset output
    next_st.sig.sys_reset_out = reset_req;
    // RQ23: clear on read
    if (log_read) begin
      next_st.log = '0;
    end
    if (st.stopped) begin
      // frozen: timers held for service access; log held until log_read clears it
      next_st.busy = st.busy;
    end else begin
      // RQ15: follow system checkstop
      if (st.cs_sync) begin
        next_st.stopped = 1'b1;
      end
      // RQ14: own checkstop out
      if (own_stop) begin
        next_st.stopped           = 1'b1;
        next_st.sig.checkstop_out = 1'b1;
      end
      // RQ16: bus timer
      if (txn.valid & txn.expect_rsp & ~st.busy) begin
        next_st.busy      = 1'b1;
        next_st.busy_ds   = txn.direct_store;
        next_st.busy_dma  = txn.dma & ~txn.is_write;
        next_st.busy_addr = txn.addr;
        next_st.tmr       = CNT_RST;
      end else if (st.busy & (rsp.valid | bus_tmo)) begin
        next_st.busy = 1'b0;
        next_st.tmr  = CNT_RST;
      end else if (st.busy) begin
        next_st.tmr = st.tmr + 32'h1;
      end
      // RQ16: dispatch watchdog
      if (disp_pending & ~disp_done) begin
        next_st.wd = st.wd + 32'h1;
      end else begin
        next_st.wd = CNT_RST;
      end
      // RQ22: diagnostic bit picks external
      // RQ2: range error reporting
      if (rng_err) begin
        next_st.sig.ext_int       = diag_mode;
        next_st.sig.machine_check = ~diag_mode;
      end
      // RQ8: deferred write error
      if (wdp_err) begin
        next_st.sig.abort_op  = DEFER_WR_ERR;
        next_st.sig.bus_check = ~DEFER_WR_ERR;
        next_st.sig.ext_int   = next_st.sig.ext_int | diag_mode;
      end
      // RQ10: memory-mapped read parity
      if (rdp_mem & ABOVE_C2) begin
        next_st.sig.ext_int       = next_st.sig.ext_int | diag_mode;
        next_st.sig.machine_check = next_st.sig.machine_check | ~diag_mode;
      end
      // RQ11: direct_store_segment read parity
      if (rdp_ds) begin
        next_st.sig.dsi       = 1'b1;
        next_st.sig.bus_check = 1'b1;
      end
      // RQ12: dma read parity
      if (rdp_dma) begin
        next_st.sig.abort_op = 1'b1;
        next_st.sig.ext_int  = 1'b1;
      end
      // RQ13: non-fatal internal error
      if (int_err) begin
        if (st.busy_ds & st.busy & ~diag_mode) begin
          next_st.sig.dsi = 1'b1;
        end else begin
          next_st.sig.ext_int = 1'b1;
        end
      end
      // RQ17: time-out reporting
      if (bus_tmo) begin
        next_st.sig.bus_check     = 1'b1;
        next_st.sig.ext_int       = next_st.sig.ext_int | diag_mode;
        next_st.sig.machine_check = next_st.sig.machine_check | ~diag_mode;
      end
      // RQ24: capture only into an empty log; new event beats clear
      if (~next_st.log.valid) begin
        if (ap_err) begin
          // RQ6: address and parity bits
          next_st.log = '{1'b1, ERR_ADDR_PAR, txn.addr, txn.addr_par, '0};
        end else if (wdp_err) begin
          // RQ9: failing bytes kept
          next_st.log = '{1'b1, ERR_DATA_PAR, txn.addr, '0, wbad};
        end else if (rdp_err) begin
          next_st.log = '{1'b1, ERR_DATA_PAR, st.busy_addr, '0, rbad};
        end else if (rng_err) begin
          next_st.log = '{1'b1, ERR_RANGE, txn.addr, '0, '0};
        end else if (int_err | int_fatal | disp_tmo) begin
          next_st.log = '{1'b1, ERR_INTERNAL, st.busy_addr, '0, '0};
        end else if (bus_tmo) begin
          next_st.log = '{1'b1, ERR_TIMEOUT, st.busy_addr, '0, '0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // RQ20: outputs straight from state
  assign sig           = st.sig;
  assign in_checkstop  = st.stopped;
  assign log_valid     = st.log.valid;
  assign log_code      = st.log.code;
  assign log_addr      = st.log.addr;
  assign log_addr_par  = st.log.addr_par;
  assign log_bad_bytes = st.log.bad_bytes;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_range_int;
    rng_err & ~st.stopped & ~own_stop & ~st.cs_sync |=> (sig.ext_int | sig.machine_check);
  endproperty
  a_range_int: assert property (p_range_int) else $error("range error not signalled"); // RQ1

  property p_range_diag;
    rng_err & diag_mode & ~st.stopped |=> sig.ext_int & ~sig.machine_check;
  endproperty
  a_range_diag: assert property (p_range_diag) else $error("diag range not external"); // RQ2

  property p_apar_stop;
    ap_err & ~st.stopped & ABOVE_C2 |=> in_checkstop & sig.checkstop_out;
  endproperty
  a_apar_stop: assert property (p_apar_stop) else $error("address parity no checkstop"); // RQ4

  property p_apar_log;
    ap_err & ~st.stopped & ~log_valid & ~log_read |=>
      log_code == ERR_ADDR_PAR && log_addr == $past(txn.addr) && log_addr_par == $past(txn.addr_par);
  endproperty
  a_apar_log: assert property (p_apar_log) else $error("address parity not logged"); // RQ6

  property p_dma_abort;
    rdp_dma & ~st.stopped |=> sig.abort_op & sig.ext_int;
  endproperty
  a_dma_abort: assert property (p_dma_abort) else $error("dma parity not aborted"); // RQ12

  property p_ds_dsi;
    rdp_ds & ~st.stopped |=> sig.dsi;
  endproperty
  a_ds_dsi: assert property (p_ds_dsi) else $error("direct store parity no dsi"); // RQ11

  property p_cs_in;
    checkstop_in [*3] |=> in_checkstop;
  endproperty
  a_cs_in: assert property (p_cs_in) else $error("checkstop input ignored"); // RQ15

  property p_stop_holds;
    in_checkstop |=> in_checkstop;
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("checkstop left"); // RQ14

  property p_log_hold;
    log_valid & ~log_read |=> $stable(log_code) && $stable(log_addr);
  endproperty
  a_log_hold: assert property (p_log_hold) else $error("log overwritten"); // RQ24

  property p_read_clear;
    log_read & ~ap_err & ~wdp_err & ~rdp_err & ~rng_err & ~int_err & ~int_fatal
      & ~disp_tmo & ~bus_tmo |=> ~log_valid;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("log not cleared"); // RQ23

  c_apar:  cover property (ap_err ##1 in_checkstop);
  c_tmo:   cover property (bus_tmo ##1 log_code == ERR_TIMEOUT);
  c_dma:   cover property (rdp_dma ##1 sig.abort_op);
  c_range: cover property (rng_err & diag_mode ##1 sig.ext_int);
endmodule

// file: verification/bus_partner.sv
/*
  far-side bus party model: answers reads, optionally late or silent.
  assumes txn and rsp share clk; parity odd per byte.
*/
`timescale 1ns/1ps
module bus_partner
  import sbe_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // request in, response out
  input  wire txn_t       txn,
  output rsp_t            rsp,
  // scenario controls
  input  wire logic [3:0] delay,
  input  wire logic [3:0] bad_mask,
  input  wire logic       mute
);
  logic [4:0]  cnt;                  // cycles left to answer
  logic [31:0] pat = 32'h1357_9BDF;  // idle filler, moves each cycle

  // odd parity per byte
  function automatic logic [3:0] par_of(input logic [31:0] d);
    for (int i = 0; i < 4; i++) par_of[i] = ~^d[8*i +: 8];
  endfunction

  initial rsp = '0;

  // answer reads after delay; junk on the bus when idle
  always @(posedge clk) begin
    pat          <= {pat[30:0], pat[31] ^ pat[21] ^ pat[1] ^ pat[0]};
    rsp.valid    <= 1'b0;
    rsp.data     <= pat;
    rsp.data_par <= pat[3:0];
    if (!rstn) begin
      cnt <= 5'h00;
    end else if (txn.valid && txn.expect_rsp && !txn.is_write && !mute) begin
      cnt <= {1'b0, delay} + 5'h01;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h01) begin
        rsp.valid    <= 1'b1;
        rsp.data_par <= par_of(pat) ^ bad_mask;
      end
    end
  end
endmodule

// file: verification/system_bus_error_handler_tb.sv
/*
  self-checking bench for the bus error handler.
  assumes 200 MHz clk, sync active-low reset, bus_partner on far side.
*/
`timescale 1ns/1ps
module system_bus_error_handler_tb;
  import sbe_pkg::*;
  typedef struct packed {
    logic [4:0] pulses;  // ext, mc, dsi, bus_check, abort
    err_code_t  code;
    logic [3:0] bytes;
  } exp_t;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0, rstn = 1'b0, diag_mode = 1'b0, int_err = 1'b0;
  logic int_fatal = 1'b0, reset_req = 1'b0, checkstop_in = 1'b0;
  logic log_read = 1'b0, mute = 1'b0, log_valid, in_checkstop;
  logic [3:0] delay = 4'h0, pmask = 4'h0, m, log_addr_par, log_bad_bytes;
  logic [31:0] a, log_addr;
  logic disp_pending = 1'b0, disp_done = 1'b0;
  logic [31:0] region_lo = 32'h0000_0000, region_hi = 32'h7FFF_FFFF;
  logic [31:0] installed_top = 32'h1000_0000;
  txn_t txn = '0;
  rsp_t rsp;
  err_code_t log_code;
  sig_t sig;
  exp_t exp_q[$];
  exp_t mon_e;
  int seed = 40, bad_count = 0, checked = 0;

  always #2.5 clk = ~clk;

  sys_bus_error_handler #(.SYS_CLASS(6), .RANGE_CHECK(1'b1), .DEFER_WR_ERR(1'b1),
    .BUS_TMO_LIMIT(32'h10), .DISP_TMO_LIMIT(32'h20)) dut (
    .clk(clk), .rstn(rstn), .txn(txn), .rsp(rsp), .diag_mode(diag_mode),
    .region_lo(region_lo), .region_hi(region_hi),
    .installed_top(installed_top), .int_err(int_err), .int_fatal(int_fatal),
    .disp_pending(disp_pending), .disp_done(disp_done), .reset_req(reset_req),
    .checkstop_in(checkstop_in), .log_read(log_read), .log_valid(log_valid),
    .log_code(log_code), .log_addr(log_addr), .log_addr_par(log_addr_par),
    .log_bad_bytes(log_bad_bytes), .sig(sig), .in_checkstop(in_checkstop));

  bus_partner partner (.clk(clk), .rstn(rstn), .txn(txn), .rsp(rsp),
    .delay(delay), .bad_mask(pmask), .mute(mute));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] odd_par(input logic [31:0] d);
    for (int i = 0; i < 4; i++) odd_par[i] = ~^d[8*i +: 8];
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask

  task automatic end_sim;
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic note(input logic [4:0] p, input err_code_t c, input logic [3:0] b);
    exp_q.push_back('{p, c, b});
  endtask

  // one request cycle, then one idle cycle
  task automatic send(input logic [31:0] ad, input logic wr, rd, ds, dm,
                      input logic [3:0] apf, dpf);
    txn.valid = 1'b1;
    txn.addr = ad;
    txn.addr_par = odd_par(ad) ^ apf;
    txn.data = $random(seed);
    txn.data_par = odd_par(txn.data) ^ dpf;
    {txn.is_write, txn.expect_rsp, txn.direct_store, txn.dma} = {wr, rd, ds, dm};
    step(1);
    txn.valid = 1'b0;
    txn.data = ~txn.data;
    step(1);
  endtask

  task automatic pulse_err(input logic fatal);
    {int_fatal, int_err} = {fatal, ~fatal};
    step(1);
    {int_fatal, int_err} = 2'b00;
    step(1);
  endtask

  // bounded wait until every noted result was seen
  task automatic drain;
    for (int i = 0; i < 80 && exp_q.size() != 0; i++) step(1);
    if (exp_q.size() != 0) begin
      $display("unexpected pending expected 0 seen %0d", exp_q.size());
      bad_count++;
      end_sim;
    end
    step(2);
  endtask

  task automatic clear_log;
    log_read = 1'b1;
    step(1);
    log_read = 1'b0;
    step(2);
    chk("log_valid", 0, log_valid);
  endtask

  task automatic reset_dut;
    rstn = 1'b0;
    step(16);
    rstn = 1'b1;
    step(1);
  endtask

  // ----------------------------------------------------------------
  // monitor: each pulse takes the oldest note
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (rstn && sig[6:2] !== 5'h00) begin
      if (exp_q.size() == 0) begin
        $display("unexpected pulses expected 00 seen %h", sig[6:2]);
        bad_count++;
      end else begin
        mon_e = exp_q.pop_front();
        chk("pulses", mon_e.pulses, sig[6:2]);
        chk("log_code", mon_e.code, log_code);
        chk("bad_bytes", mon_e.bytes, log_bad_bytes);
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_dut;
    for (int d = 0; d < 2; d++) begin
      diag_mode = d[0];
      installed_top = 32'h1000_0000 | (32'($random(seed)) & 32'h0FFF_0000);
      delay = 4'($random(seed) & 3);
      m = 4'($random(seed)) | 4'h1;
      a = 32'h2000_0000 | (32'($random(seed)) & 32'h0FFF_FFFC);
      note(d ? 5'h10 : 5'h08, ERR_RANGE, 4'h0);
      send(a, 1, 0, 0, 0, 4'h0, 4'h0);
      drain;
      chk("log_addr", a, log_addr);
      clear_log;
      note(d ? 5'h11 : 5'h01, ERR_DATA_PAR, m);
      send(a & 32'h0FFF_FFFC, 1, 0, 0, 0, 4'h0, m);
      drain;
      clear_log;
      pmask = m;
      note(d ? 5'h10 : 5'h08, ERR_DATA_PAR, m);
      send(32'h0000_0100, 0, 1, 0, 0, 4'h0, 4'h0);
      drain;
      pmask = 4'h0;
      clear_log;
      mute = 1'b1;
      note(d ? 5'h12 : 5'h0A, ERR_TIMEOUT, 4'h0);
      send(32'h0000_0200, 0, 1, 0, 0, 4'h0, 4'h0);
      drain;
      chk("log_addr", 32'h0000_0200, log_addr);
      mute = 1'b0;
      clear_log;
      note(5'h10, ERR_INTERNAL, 4'h0);
      pulse_err(0);
      drain;
      clear_log;
    end
    diag_mode = 1'b0;
    pmask = 4'h2;
    note(5'h06, ERR_DATA_PAR, 4'h2);
    send(32'h0000_0300, 0, 1, 1, 0, 4'h0, 4'h0);
    drain;
    clear_log;
    pmask = 4'h8;
    note(5'h11, ERR_DATA_PAR, 4'h8);
    send(32'h0000_0400, 0, 1, 0, 1, 4'h0, 4'h0);
    drain;
    pmask = 4'h0;
    clear_log;
    delay = 4'h8;
    send(32'h0000_0500, 0, 1, 1, 0, 4'h0, 4'h0);
    note(5'h04, ERR_INTERNAL, 4'h0);
    pulse_err(0);
    drain;
    step(8);
    delay = 4'h0;
    clear_log;
    note(5'h10, ERR_INTERNAL, 4'h0);
    pulse_err(0);
    drain;
    note(5'h08, ERR_INTERNAL, 4'h0);
    send(32'h3000_0000, 1, 0, 0, 0, 4'h0, 4'h0);
    drain;
    clear_log;
    send(32'h8000_0000, 1, 0, 0, 0, 4'h0, 4'h0);
    step(1);
    chk("log_valid", 0, log_valid);
    reset_req = 1'b1;
    step(2);
    chk("sys_reset_out", 1, sig.sys_reset_out);
    reset_req = 1'b0;
    step(2);
    chk("sys_reset_out", 0, sig.sys_reset_out);
    a = 32'($random(seed)) & 32'h0FFF_FFFF;
    send(a, 0, 0, 0, 0, 4'h4, 4'h0);
    chk("in_checkstop", 1, in_checkstop);
    chk("checkstop_out", 1, sig.checkstop_out);
    chk("log_code", ERR_ADDR_PAR, log_code);
    chk("log_addr", a, log_addr);
    chk("log_addr_par", odd_par(a) ^ 4'h4, log_addr_par);
    pulse_err(0);
    step(3);
    chk("log_code", ERR_ADDR_PAR, log_code);
    reset_dut;
    pulse_err(1);
    chk("checkstop_out", 1, sig.checkstop_out);
    reset_dut;
    disp_pending = 1'b1;
    step(20);
    disp_done = 1'b1;
    step(1);
    disp_done = 1'b0;
    step(20);
    chk("in_checkstop", 0, in_checkstop);
    step(14);
    chk("in_checkstop", 1, in_checkstop);
    chk("log_code", ERR_INTERNAL, log_code);
    disp_pending = 1'b0;
    reset_dut;
    checkstop_in = 1'b1;
    step(4);
    chk("in_checkstop", 1, in_checkstop);
    chk("checkstop_out", 0, sig.checkstop_out);
    checkstop_in = 1'b0;
    reset_dut;
    end_sim;
  end
endmodule
